//--- shared/ssea_consts.svh
// Register offsets, field positions, reset values and bus constants of the
// status/enable aggregator. Assumes word-aligned APB byte addressing.
`ifndef SSEA_CONSTS_SVH
`define SSEA_CONSTS_SVH
`define SSEA_IDX_STS1       8'h10
`define SSEA_IDX_STS2       8'h11
`define SSEA_IDX_STS3       8'h12
`define SSEA_IDX_STS4       8'h13
`define SSEA_IDX_STS5       8'h14
`define SSEA_IDX_GAP        8'h15
`define SSEA_IDX_EN1        8'h16
`define SSEA_IDX_EN2        8'h17
`define SSEA_IDX_EN3        8'h18
`define SSEA_IDX_EN4        8'h19
`define SSEA_IDX_EN5        8'h1a
`define SSEA_IDX_IRQ_STS    8'h20
`define SSEA_IDX_IRQ_MASK   8'h21
`define SSEA_RST_BYTE       8'h00
`define SSEA_STS1_RST       8'h02
`define SSEA_STS2_SRC_MASK  8'h13
`define SSEA_STS2_IR_BIT    2
`define SSEA_STS3_MASK      8'hf7
`define SSEA_STS4_MASK      8'hff
`define SSEA_STS5_MASK      8'hcf
`define SSEA_EN1_MASK       8'h3e
`define SSEA_EN2_MASK       8'hf7
`define SSEA_EN2_WAKE_BIT   5
`define SSEA_EN2_SER_BIT    6
`define SSEA_EN2_PIN_BIT    7
`define SSEA_IRQ_MASK       8'h07
`endif

//--- shared/ssea_pkg.sv
// Types of the status/enable aggregator.
// Assumes ssea_consts.svh for all numeric constants.
package ssea_pkg;
  typedef struct packed {
    logic [7:0] sts2;
    logic [7:0] sts3;
    logic [7:0] sts4;
    logic [7:0] sts5;
    logic [7:0] en1;
    logic [7:0] en2;
    logic [7:0] en3;
    logic [7:0] en4;
    logic [7:0] en5;
    logic [7:0] irq_sts;
    logic [7:0] irq_mask;
    logic       ir_prev;
    logic [31:0] prdata;
  } ssea_state_t;

  typedef struct packed {
    logic [7:0] prev;
  } ssea_edge_state_t;
endpackage : ssea_pkg

//--- logic/ssea_edge_det.sv
// Rising-edge detector for a byte of event sources.
// Assumes sources synchronous to i_ref_clk.
`timescale 1ns/100ps
`include "ssea_consts.svh"
module ssea_edge_det
  import ssea_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_srst,
  input  wire logic [7:0] i_level,
  output logic      [7:0] o_rise
);
  ssea_edge_state_t st;
  ssea_edge_state_t next_st;

  always_comb begin
    next_st.prev = i_level;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st.prev <= `SSEA_RST_BYTE;
    end else begin
      st <= next_st;
    end
  end

  // Pulse is combinational so the event lands in the status the same edge
  assign o_rise = i_level & ~st.prev;
endmodule : ssea_edge_det

//--- logic/ssea_aggregator.sv
// Interrupt status and enable aggregator with APB register access.
// Assumes sources synchronous to i_ref_clk; APB master per AMBA 3.
`timescale 1ns/100ps
`include "ssea_consts.svh"
module ssea_aggregator
  import ssea_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_srst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic      [31:0] o_prdata,
  output logic             o_pslverr,
  input  wire logic        i_mouse_irq_flag,
  input  wire logic        i_keyboard_irq_flag,
  input  wire logic        i_kbc_port_pin_flag,
  input  wire logic        i_infrared_receive_in,
  input  wire logic        i_infrared_receive_alt_in,
  input  wire logic        i_infrared_select_alt,
  input  wire logic        i_parallel_active,
  input  wire logic        i_parallel_ack_n,
  input  wire logic        i_serial_two_irq_flag,
  input  wire logic        i_serial_one_irq_flag,
  input  wire logic        i_floppy_irq_flag,
  input  wire logic        i_midi_irq_flag,
  input  wire logic [7:0]  i_gp_three_src,
  input  wire logic [7:0]  i_gp_four_src,
  input  wire logic [7:0]  i_gp_five_src,
  output logic             o_group_mgmt_irq,
  output logic             o_mgmt_irq_pin_n,
  output logic             o_group_irq_serial,
  output logic             o_group_irq_wake,
  output logic             o_irq
);
  ssea_state_t st;
  ssea_state_t next_st;

  logic [7:0]  rise3;
  logic [7:0]  rise4;
  logic [7:0]  rise5;
  logic [7:0]  sts1;
  logic [7:0]  sts2_view;
  logic [7:0]  idx;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        ir_sel;
  logic        ir_edge;
  logic        group;
  logic [7:0]  wbyte;
  logic [7:0]  rd_byte;
  logic [7:0]  evt;

  ssea_edge_det u_edge3 (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_level   (i_gp_three_src),
    .o_rise    (rise3)
  );
  ssea_edge_det u_edge4 (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_level   (i_gp_four_src),
    .o_rise    (rise4)
  );
  ssea_edge_det u_edge5 (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_level   (i_gp_five_src),
    .o_rise    (rise5)
  );

  assign idx     = i_paddr[9:2];
  assign wbyte   = i_pwdata[7:0];
  assign wr_en   = i_psel & i_penable & i_pwrite;
  assign rd_en   = i_psel & i_penable & ~i_pwrite;
  assign addr_ok = (i_paddr[1:0] == 2'h0) && (i_paddr[11:10] == 2'h0) &&
                   (((idx >= `SSEA_IDX_STS1) && (idx <= `SSEA_IDX_EN5)) ||
                    (idx == `SSEA_IDX_IRQ_STS) || (idx == `SSEA_IDX_IRQ_MASK));

  // Parallel flag reads one while the port is off, else follows acknowledge
  assign sts1 = {2'h0, i_midi_irq_flag, i_floppy_irq_flag, i_serial_one_irq_flag,
                 i_serial_two_irq_flag, (~i_parallel_active) | i_parallel_ack_n,
                 1'b0};
  assign sts2_view = {3'h0, i_kbc_port_pin_flag, 1'b0, st.sts2[`SSEA_STS2_IR_BIT],
                      i_keyboard_irq_flag, i_mouse_irq_flag};

  assign ir_sel  = i_infrared_select_alt ? i_infrared_receive_alt_in : i_infrared_receive_in;
  assign ir_edge = ir_sel ^ st.ir_prev;

  // Any enabled pair raises the group line; enable one bits 1..5 gate status one
  assign group = |(sts1 & st.en1 & `SSEA_EN1_MASK) | |(sts2_view & st.en2 & 8'h17) |
                 |(st.sts3 & st.en3) | |(st.sts4 & st.en4) |
                 |(st.sts5 & st.en5);

  always_comb begin
    rd_byte = `SSEA_RST_BYTE;
    unique case (idx)
      `SSEA_IDX_STS1:     rd_byte = sts1;
      `SSEA_IDX_STS2:     rd_byte = sts2_view;
      `SSEA_IDX_STS3:     rd_byte = st.sts3;
      `SSEA_IDX_STS4:     rd_byte = st.sts4;
      `SSEA_IDX_STS5:     rd_byte = st.sts5;
      `SSEA_IDX_GAP:      rd_byte = `SSEA_RST_BYTE;
      `SSEA_IDX_EN1:      rd_byte = st.en1;
      `SSEA_IDX_EN2:      rd_byte = st.en2;
      `SSEA_IDX_EN3:      rd_byte = st.en3;
      `SSEA_IDX_EN4:      rd_byte = st.en4;
      `SSEA_IDX_EN5:      rd_byte = st.en5;
      `SSEA_IDX_IRQ_STS:  rd_byte = st.irq_sts;
      `SSEA_IDX_IRQ_MASK: rd_byte = st.irq_mask;
      default:            rd_byte = `SSEA_RST_BYTE;
    endcase
  end

  // Interrupt events: group level, infrared edge, any status-three..five source rise
  assign evt = {5'h0, |(rise3 | rise4 | rise5), ir_edge, group};

  always_comb begin
    next_st         = st;
    next_st.ir_prev = ir_sel;
    next_st.prdata  = st.prdata;
    if (rd_en) begin
      next_st.prdata = {24'h0, addr_ok ? rd_byte : `SSEA_RST_BYTE};
    end
    // Read clears first so an edge in the same cycle still sets the flag
    if (rd_en && addr_ok && (idx == `SSEA_IDX_STS2)) begin
      next_st.sts2[`SSEA_STS2_IR_BIT] = 1'b0;
    end
    if (ir_edge) begin
      next_st.sts2[`SSEA_STS2_IR_BIT] = 1'b1;
    end
    if (wr_en && addr_ok) begin
      unique case (idx)
        `SSEA_IDX_STS3:     next_st.sts3 = st.sts3 & ~wbyte;
        `SSEA_IDX_STS4:     next_st.sts4 = st.sts4 & ~wbyte;
        `SSEA_IDX_STS5:     next_st.sts5 = st.sts5 & ~wbyte;
        `SSEA_IDX_EN1:      next_st.en1 = wbyte & `SSEA_EN1_MASK;
        `SSEA_IDX_EN2:      next_st.en2 = wbyte & `SSEA_EN2_MASK;
        `SSEA_IDX_EN3:      next_st.en3 = wbyte & `SSEA_STS3_MASK;
        `SSEA_IDX_EN4:      next_st.en4 = wbyte & `SSEA_STS4_MASK;
        `SSEA_IDX_EN5:      next_st.en5 = wbyte & `SSEA_STS5_MASK;
        `SSEA_IDX_IRQ_STS:  next_st.irq_sts = st.irq_sts & ~wbyte;
        `SSEA_IDX_IRQ_MASK: next_st.irq_mask = wbyte & `SSEA_IRQ_MASK;
        default:            next_st.prdata = st.prdata;
      endcase
    end
    // Sets after clears: a source event in the clear cycle survives
    next_st.sts3    = next_st.sts3 | (rise3 & `SSEA_STS3_MASK);
    next_st.sts4    = next_st.sts4 | (rise4 & `SSEA_STS4_MASK);
    next_st.sts5    = next_st.sts5 | (rise5 & `SSEA_STS5_MASK);
    next_st.irq_sts = next_st.irq_sts | evt;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_pready           = 1'b1;
  assign o_pslverr          = i_psel & i_penable & ~addr_ok;
  assign o_prdata           = st.prdata;
  assign o_group_mgmt_irq   = group;
  assign o_mgmt_irq_pin_n   = ~(group & st.en2[`SSEA_EN2_PIN_BIT]);
  assign o_group_irq_serial = group & st.en2[`SSEA_EN2_SER_BIT];
  assign o_group_irq_wake   = group & st.en2[`SSEA_EN2_WAKE_BIT];
  assign o_irq              = |(st.irq_sts & st.irq_mask);

  a_sts3_latch: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (rise3[0] && !i_srst) |=> st.sts3[0]) else $error("status three missed event");
  a_w1c_clear: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (wr_en && idx == `SSEA_IDX_STS4 && wbyte[1] && !rise4[1]) |=> !st.sts4[1])
    else $error("write one did not clear");
  a_ir_set: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    ir_edge |=> st.sts2[2]) else $error("infrared edge lost");
  a_ir_read_clr: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (rd_en && idx == `SSEA_IDX_STS2 && !ir_edge) |=> !st.sts2[2])
    else $error("infrared flag not cleared by read");
  a_gap_zero: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (rd_en && idx == `SSEA_IDX_GAP && i_paddr[1:0] == 2'h0 && i_paddr[11:10] == 2'h0)
    |=> o_prdata == 32'h0) else $error("reserved read not zero");
  a_en1_gate: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (st.en1 == 8'h0 && st.en2[4:0] == 5'h0 && st.en3 == 8'h0 && st.en4 == 8'h0 &&
     st.en5 == 8'h0) |-> !o_group_mgmt_irq) else $error("group high while gated");
  a_group_any: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (|(st.sts3 & st.en3)) |-> o_group_mgmt_irq) else $error("group low with pair");
  a_pin_route: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !o_mgmt_irq_pin_n |-> (group && st.en2[7])) else $error("pin driven unrouted");
  a_src_follow: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    $rose(i_mouse_irq_flag) |-> sts2_view[0]) else $error("mouse bit not following");
  // Checked the edge after a reset edge, so the unknown power-up state never reaches it
  a_reset_zero: assert property (@(posedge i_ref_clk)
    i_srst |=> (st.sts3 == 8'h0 && st.en1 == 8'h0)) else $error("reset not zero");
  a_par_off: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !i_parallel_active |-> sts1[1]) else $error("parallel flag low while off");

  c_ir_edge:  cover property (@(posedge i_ref_clk) disable iff (i_srst) ir_edge ##1 rd_en);
  c_group:    cover property (@(posedge i_ref_clk) disable iff (i_srst) $rose(group));
  c_w1c:      cover property (@(posedge i_ref_clk) disable iff (i_srst)
    wr_en && idx == `SSEA_IDX_STS5);
  c_irq:      cover property (@(posedge i_ref_clk) disable iff (i_srst) $rose(o_irq));
endmodule : ssea_aggregator

//--- sim/ssea_host_model.sv
// Host-side model of the chipset that receives the management interrupt.
// Assumes the pin is driven synchronously to i_ref_clk.
`timescale 1ns/100ps
module ssea_host_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_srst,
  input  wire logic       i_mgmt_irq_pin_n,
  output logic      [7:0] o_pin_events
);
  logic prev_n;
  // Counts handler entries, so a pin stuck low shows as too few events
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      prev_n       <= 1'h1;
      o_pin_events <= 8'h00;
    end else begin
      prev_n <= i_mgmt_irq_pin_n;
      if (prev_n && !i_mgmt_irq_pin_n) begin
        o_pin_events <= o_pin_events + 8'h01;
      end
    end
  end
endmodule : ssea_host_model

//--- sim/tb_top.sv
// Self-checking bench of the status/enable aggregator over APB.
// Assumes the package, the constants header and the host model are compiled first.
`timescale 1ns/100ps
`include "ssea_consts.svh"
module tb_top;
  logic        clk = '0, srst = '1, psel = '0, pen = '0, pwr = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, grp, pin_n, ser_o, wake_o, irq;
  logic        mouse = '0, kbd = '0, kpin = '0, ir = '0, ir_alt = '0, ir_sel = '0;
  logic        par_act = '0, ack_n = '0, ser2 = '0, ser1 = '0, flop = '0, midi = '0;
  logic [7:0]  gp3 = '0, gp4 = '0, gp5 = '0, pin_events;
  int          miscompares = 0, comparisons = 0, cycles = 0;

  always #5 clk = ~clk;

  ssea_aggregator u_ssea_aggregator (
    .i_ref_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_mouse_irq_flag(mouse), .i_keyboard_irq_flag(kbd),
    .i_kbc_port_pin_flag(kpin), .i_infrared_receive_in(ir),
    .i_infrared_receive_alt_in(ir_alt), .i_infrared_select_alt(ir_sel),
    .i_parallel_active(par_act), .i_parallel_ack_n(ack_n),
    .i_serial_two_irq_flag(ser2), .i_serial_one_irq_flag(ser1),
    .i_floppy_irq_flag(flop), .i_midi_irq_flag(midi), .i_gp_three_src(gp3),
    .i_gp_four_src(gp4), .i_gp_five_src(gp5), .o_group_mgmt_irq(grp),
    .o_mgmt_irq_pin_n(pin_n), .o_group_irq_serial(ser_o), .o_group_irq_wake(wake_o),
    .o_irq(irq));

  ssea_host_model u_ssea_host_model (
    .i_ref_clk(clk), .i_srst(srst), .i_mgmt_irq_pin_n(pin_n), .o_pin_events(pin_events));

  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'h1;
    pwr    <= w;
    paddr  <= {2'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    psel <= 1'h0;
    pen  <= 1'h0;
  endtask : apb

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Read data is registered, so it is looked at one half cycle after the access edge
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'h0, idx, 32'h0);
    @(negedge clk);
    chk($sformatf("reg %h", idx), exp, prdata);
  endtask : rd

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'h1, idx, d);
    @(negedge clk);
  endtask : wr

  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic t_reset();
    for (int i = `SSEA_IDX_STS2; i <= `SSEA_IDX_EN1; i++) rd(8'(i), 32'h0);
    wr(`SSEA_IDX_GAP, 32'hff);
    rd(`SSEA_IDX_GAP, 32'h0);
    rd(8'hff, 32'h0);
  endtask : t_reset

  task automatic t_level();
    @(posedge clk);
    {mouse, kbd, kpin} <= 3'h7;
    settle();
    rd(`SSEA_IDX_STS2, 32'h13);
    wr(`SSEA_IDX_STS2, 32'hff);
    rd(`SSEA_IDX_STS2, 32'h13);
    @(posedge clk);
    {mouse, kbd, kpin} <= 3'h0;
    settle();
    rd(`SSEA_IDX_STS2, 32'h0);
  endtask : t_level

  task automatic t_ir();
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      ir_sel <= s[0];
      settle();
      apb(1'h0, `SSEA_IDX_STS2, 32'h0);
      @(posedge clk);
      if (s == 0) ir_alt <= ~ir_alt;
      else ir <= ~ir;
      settle();
      rd(`SSEA_IDX_STS2, 32'h0);
      @(posedge clk);
      if (s == 0) ir <= ~ir;
      else ir_alt <= ~ir_alt;
      settle();
      rd(`SSEA_IDX_STS2, 32'h04);
      rd(`SSEA_IDX_STS2, 32'h0);
    end
  endtask : t_ir

  task automatic t_gp();
    wr(`SSEA_IDX_IRQ_MASK, 32'h04);
    chk("irq idle", 32'h0, {31'h0, irq});
    @(posedge clk);
    {gp3, gp4, gp5} <= 24'h5aa5ff;
    settle();
    {gp3, gp4, gp5} <= 24'h0;
    settle();
    rd(`SSEA_IDX_STS3, 32'h52);
    rd(`SSEA_IDX_STS4, 32'ha5);
    rd(`SSEA_IDX_STS5, 32'hcf);
    wr(`SSEA_IDX_STS3, 32'h02);
    wr(`SSEA_IDX_STS4, 32'h01);
    wr(`SSEA_IDX_STS5, 32'h40);
    rd(`SSEA_IDX_STS3, 32'h50);
    rd(`SSEA_IDX_STS4, 32'ha4);
    rd(`SSEA_IDX_STS5, 32'h8f);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(`SSEA_IDX_IRQ_MASK, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`SSEA_IDX_IRQ_MASK, 32'h04);
    wr(`SSEA_IDX_IRQ_STS, 32'h04);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask : t_gp

  task automatic t_gate();
    wr(`SSEA_IDX_EN2, 32'h80);
    @(posedge clk);
    {par_act, ack_n, ser2, ser1, flop, midi} <= 6'h2f;
    settle();
    wr(`SSEA_IDX_EN1, 32'h02);
    chk("group gated flag low", 32'h0, {31'h0, grp});
    @(posedge clk);
    ack_n <= 1'h1;
    for (int i = 1; i <= 5; i++) begin
      wr(`SSEA_IDX_EN1, 32'h1 << i);
      chk($sformatf("group en bit %0d", i), 32'h1, {31'h0, grp});
      chk("pin", 32'h0, {31'h0, pin_n});
      wr(`SSEA_IDX_EN1, 32'h0);
      chk("group off", 32'h0, {31'h0, grp});
    end
    chk("host events", 32'h5, {24'h0, pin_events});
    @(posedge clk);
    {par_act, ack_n} <= 2'h0;
    settle();
    wr(`SSEA_IDX_EN1, 32'hff);
    rd(`SSEA_IDX_EN1, 32'h3e);
    rd(`SSEA_IDX_STS1, 32'h3e);
    wr(`SSEA_IDX_EN2, 32'h60);
    chk("route", 32'h7, {29'h0, pin_n, ser_o, wake_o});
  endtask : t_gate

  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    t_reset();
    t_level();
    t_ir();
    t_gp();
    t_gate();
    print_verdict();
  end
endmodule : tb_top
